// ### logic/fes_consts.svh
`ifndef FES_CONSTS_SVH
`define FES_CONSTS_SVH

`define FES_CLK_NS 100

`define FES_OP_WRITE_LATCH_SET 8'h06
`define FES_OP_BLOCK_ERASE 8'hD8
`define FES_OP_CHIP_ERASE_A 8'h60
`define FES_OP_CHIP_ERASE_B 8'hC7
`define FES_OP_DEEP_SLEEP 8'hB9
`define FES_OP_WAKE_PART 8'hAB
`define FES_OP_MAKER_PART 8'h90
`define FES_OP_MAKER_PART_DUAL 8'h92

`define FES_OPCODE_BITS 6'h08
`define FES_FRAME_BITS 6'h20
`define FES_BITS_MAX 6'h3F
`define FES_BLOCK_SPAN_ALL 8'h80
`define FES_BP_ALL 3'h7

`define FES_T_BLOCK_ERASE_NS 1000000
`define FES_T_CHIP_ERASE_NS 5000000
`define FES_T_SLEEP_ENTRY_NS 3000
`define FES_T_RELEASE_NS 3000
`define FES_T_RELEASE_CODE_NS 6000

`define FES_HALF_SCLK 4'h4
`define FES_TX_OPCODE_CLKS 8'h08
`define FES_TX_ADDR_CLKS 8'h18
`define FES_TX_ADDR_CLKS_DUAL 8'h0C

`define FES_REG_CTRL 4'h0
`define FES_REG_ADDR 4'h4
`define FES_REG_STATUS 4'h8
`define FES_REG_RDATA 4'hC
`define FES_CTRL_HAS_ADDR 8
`define FES_CTRL_DUAL 9
`define FES_CTRL_RDLEN_LSB 10
`define FES_CTRL_RDLEN_MSB 13

`endif

// ### logic/fes_pkg.sv
package fes_pkg;

  typedef enum logic [1:0] {
    pwr_standby = 2'h0,
    pwr_entry = 2'h1,
    pwr_sleep = 2'h3,
    pwr_waking = 2'h2
  } fes_pwr_t;

  typedef enum logic [2:0] {
    hst_idle = 3'h0,
    hst_sel = 3'h1,
    hst_shift = 3'h3,
    hst_desel = 3'h2,
    hst_gap = 3'h6
  } fes_hst_t;

endpackage : fes_pkg

// ### logic/fes_if.sv
`timescale 1ns/1ps
interface fes_if;
  logic cs_b;
  logic sclk;
  logic hst_io0_out;
  logic hst_io0_oe;
  logic hst_io1_out;
  logic hst_io1_oe;
  logic dev_io0_out;
  logic dev_io0_oe;
  logic dev_io1_out;
  logic dev_io1_oe;
  logic io0;
  logic io1;

  // Idle lines float high as behind a pull-up
  assign io0 = hst_io0_oe ? hst_io0_out : (dev_io0_oe ? dev_io0_out : 1'b1);
  assign io1 = hst_io1_oe ? hst_io1_out : (dev_io1_oe ? dev_io1_out : 1'b1);

  modport dev (
    input cs_b, sclk, io0, io1,
    output dev_io0_out, dev_io0_oe, dev_io1_out, dev_io1_oe
  );

  modport hst (
    output cs_b, sclk, hst_io0_out, hst_io0_oe, hst_io1_out, hst_io1_oe,
    input io0, io1
  );
endinterface : fes_if

// ### logic/fes_device.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "fes_consts.svh"
module fes_device #(
  parameter int unsigned BLOCK_ERASE_CYC =
    (`FES_T_BLOCK_ERASE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS,
  parameter int unsigned CHIP_ERASE_CYC =
    (`FES_T_CHIP_ERASE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS,
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE = 8'hA5,
  parameter logic [7:0] PART_CODE = 8'h3C
) (
  fes_if.dev link,
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] protect,
  output logic busy_flag,
  output logic write_latch,
  output logic deep_sleep,
  output logic erasing_chip,
  output logic [6:0] erase_block
);

  localparam int unsigned SLEEP_ENTRY_CYC =
    (`FES_T_SLEEP_ENTRY_NS + `FES_CLK_NS - 1) / `FES_CLK_NS;
  localparam int unsigned RELEASE_CYC =
    (`FES_T_RELEASE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS;
  localparam int unsigned RELEASE_CODE_CYC =
    (`FES_T_RELEASE_CODE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS;

  function automatic logic [5:0] sat_add(input logic [5:0] b, input logic [5:0] inc);
    logic [6:0] s;
    s = {1'b0, b} + {1'b0, inc};
    sat_add = s[6] ? `FES_BITS_MAX : s[5:0];
  endfunction : sat_add

  // Top (bp[3]=0) or bottom region of 2^(n-1) blocks, all 128 at n=7; bp[4] plays no part per block
  function automatic logic blk_protected(input logic [4:0] bp, input logic [6:0] blk);
    logic [7:0] span;
    span = 8'h00;
    if (bp[2:0] == `FES_BP_ALL) begin
      span = `FES_BLOCK_SPAN_ALL;
    end else if (bp[2:0] != 3'h0) begin
      span = 8'h01 << (bp[2:0] - 3'h1);
    end
    if (bp[3]) begin
      blk_protected = {1'b0, blk} < span;
    end else begin
      blk_protected = {1'b0, blk} >= (`FES_BLOCK_SPAN_ALL - span);
    end
  endfunction : blk_protected

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {cs_b, sclk, io1, io0}
  logic [3:0] sync1, sync2, sync3;

  // Idle pin levels, so leaving reset shows no false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {sync1, sync2, sync3} <= 12'hBBB;
    end else begin
      sync1 <= {link.cs_b, link.sclk, link.io1, link.io0};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic selected, cs_fall, cs_rise, sclk_rise, sclk_fall;
  assign selected = ~sync2[3];
  assign cs_fall = ~sync2[3] & sync3[3];
  assign cs_rise = sync2[3] & ~sync3[3];
  assign sclk_rise = selected & sync2[2] & ~sync3[2];
  assign sclk_fall = selected & ~sync2[2] & sync3[2];

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver
  logic [5:0] bits, next_bits;
  logic [7:0] opcode;
  logic [31:0] rx, next_rx;
  logic dual_in;
  fes_pkg::fes_pwr_t pwr;

  assign dual_in = (bits >= `FES_OPCODE_BITS) && (opcode == `FES_OP_MAKER_PART_DUAL);
  assign next_bits = sat_add(bits, dual_in ? 6'h02 : 6'h01);
  assign next_rx = dual_in ? {rx[29:0], sync2[1], sync2[0]} : {rx[30:0], sync2[0]};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bits <= 6'h00;
      rx <= 32'h0000_0000;
      opcode <= 8'h00;
    end else if (cs_fall) begin
      bits <= 6'h00;
    end else if (sclk_rise) begin
      bits <= next_bits;
      rx <= next_rx;
      if (bits == `FES_OPCODE_BITS - 6'h01) begin
        opcode <= next_rx[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode at the select rise; exact bit counts guard every action except wake, which takes 8 or at least 32 bits
  logic standby_idle, op_exact, frame_exact;
  logic do_wel, do_be, do_ce, do_dp, do_wake;

  assign standby_idle = (pwr == fes_pkg::pwr_standby) && !busy_flag;
  assign op_exact = bits == `FES_OPCODE_BITS;
  assign frame_exact = bits == `FES_FRAME_BITS;
  assign do_wel = cs_rise && standby_idle && op_exact && opcode == `FES_OP_WRITE_LATCH_SET;
  assign do_be = cs_rise && standby_idle && frame_exact && write_latch &&
                 opcode == `FES_OP_BLOCK_ERASE &&
                 !blk_protected(protect, rx[22:16]);
  assign do_ce = cs_rise && standby_idle && op_exact && write_latch &&
                 (opcode == `FES_OP_CHIP_ERASE_A || opcode == `FES_OP_CHIP_ERASE_B) &&
                 protect == 5'h00;
  assign do_dp = cs_rise && standby_idle && op_exact &&
                 opcode == `FES_OP_DEEP_SLEEP;
  assign do_wake = cs_rise && pwr == fes_pkg::pwr_sleep &&
                   (op_exact || bits >= `FES_FRAME_BITS) &&
                   opcode == `FES_OP_WAKE_PART;

  ////////////////////////////////////////////////////////////////////////////
  // Power mode
  logic [31:0] ptimer;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwr <= fes_pkg::pwr_standby;
      ptimer <= 32'h0000_0000;
      deep_sleep <= 1'b0;
    end else begin
      unique case (pwr)
        fes_pkg::pwr_standby: begin
          if (do_dp) begin
            pwr <= fes_pkg::pwr_entry;
            ptimer <= SLEEP_ENTRY_CYC - 1;
          end
        end
        fes_pkg::pwr_entry: begin
          if (ptimer == 32'h0000_0000) begin
            pwr <= fes_pkg::pwr_sleep;
            deep_sleep <= 1'b1;
          end else begin
            ptimer <= ptimer - 32'h0000_0001;
          end
        end
        fes_pkg::pwr_sleep: begin
          if (do_wake) begin
            pwr <= fes_pkg::pwr_waking;
            deep_sleep <= 1'b0;
            ptimer <= op_exact ? RELEASE_CYC - 1 : RELEASE_CODE_CYC - 1;
          end
        end
        fes_pkg::pwr_waking: begin
          // Commands stay ignored until the release delay is over
          if (ptimer == 32'h0000_0000) begin
            pwr <= fes_pkg::pwr_standby;
          end else begin
            ptimer <= ptimer - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed erase
  logic [31:0] etimer;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_flag <= 1'b0;
      etimer <= 32'h0000_0000;
      erasing_chip <= 1'b0;
      erase_block <= 7'h00;
    end else if (do_be) begin
      busy_flag <= 1'b1;
      etimer <= BLOCK_ERASE_CYC - 1;
      erasing_chip <= 1'b0;
      erase_block <= rx[22:16];
    end else if (do_ce) begin
      busy_flag <= 1'b1;
      etimer <= CHIP_ERASE_CYC - 1;
      erasing_chip <= 1'b1;
    end else if (busy_flag) begin
      if (etimer == 32'h0000_0000) begin
        busy_flag <= 1'b0;
      end else begin
        etimer <= etimer - 32'h0000_0001;
      end
    end
  end

  // Cleared at erase start, which is well before completion
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_latch <= 1'b0;
    end else if (do_wel) begin
      write_latch <= 1'b1;
    end else if (do_be || do_ce) begin
      write_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identifier output, rotating so it repeats until select rises
  logic out_on, out_dual, read_ok;
  logic [15:0] out_sh, id_word;

  assign read_ok = !busy_flag && (
    (opcode == `FES_OP_WAKE_PART &&
     (pwr == fes_pkg::pwr_standby || pwr == fes_pkg::pwr_sleep)) ||
    (pwr == fes_pkg::pwr_standby &&
     (opcode == `FES_OP_MAKER_PART || opcode == `FES_OP_MAKER_PART_DUAL)));
  assign id_word = (opcode == `FES_OP_WAKE_PART) ? {PART_CODE, PART_CODE} :
                   next_rx[0] ? {PART_CODE, MAKER_CODE} : {MAKER_CODE, PART_CODE};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_on <= 1'b0;
      out_dual <= 1'b0;
      out_sh <= 16'h0000;
    end else if (!selected) begin
      out_on <= 1'b0;
    end else if (sclk_rise && next_bits == `FES_FRAME_BITS && !out_on && read_ok) begin
      out_on <= 1'b1;
      out_dual <= dual_in;
      out_sh <= id_word;
    end else if (sclk_fall && out_on) begin
      out_sh <= out_dual ? {out_sh[13:0], out_sh[15:14]} : {out_sh[14:0], out_sh[15]};
    end
  end

  // MSB first on the falling clock edge; io1 carries the upper bit of a pair
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {link.dev_io1_out, link.dev_io0_out, link.dev_io1_oe, link.dev_io0_oe} <= 4'h0;
    end else if (!selected) begin
      {link.dev_io1_oe, link.dev_io0_oe} <= 2'h0;
    end else if (sclk_fall && out_on) begin
      link.dev_io1_out <= out_sh[15];
      link.dev_io0_out <= out_sh[14];
      link.dev_io1_oe <= 1'b1;
      link.dev_io0_oe <= out_dual;
    end
  end

endmodule : fes_device

// ### logic/fes_host.sv
`timescale 1ns/1ps
`include "fes_consts.svh"
module fes_host (
  fes_if.hst link,
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int unsigned RELEASE_CYC =
    (`FES_T_RELEASE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS;
  localparam int unsigned RELEASE_CODE_CYC =
    (`FES_T_RELEASE_CODE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS;

  fes_pkg::fes_hst_t st;
  logic [31:0] ctrl;
  logic [31:0] addr;
  logic [31:0] rdata;
  logic [31:0] tx;
  logic [3:0] ph;
  logic [7:0] ck;
  logic [7:0] tx_clks;
  logic [7:0] tot_clks;
  logic [31:0] gap;
  logic [1:0] s1;
  logic [1:0] s2;
  logic start;
  logic dual;
  logic [3:0] rdlen;
  logic [7:0] next_tx_clks;

  assign start = reg_wr && reg_addr == `FES_REG_CTRL && st == fes_pkg::hst_idle;
  assign dual = ctrl[`FES_CTRL_DUAL];
  assign rdlen = reg_wdata[`FES_CTRL_RDLEN_MSB:`FES_CTRL_RDLEN_LSB];
  // Opcode alone, or with three address bytes, so select rises on a byte end
  assign next_tx_clks = `FES_TX_OPCODE_CLKS + (!reg_wdata[`FES_CTRL_HAS_ADDR] ? 8'h00 :
    reg_wdata[`FES_CTRL_DUAL] ? `FES_TX_ADDR_CLKS_DUAL : `FES_TX_ADDR_CLKS);

  ////////////////////////////////////////////////////////////////////////////
  // Register port; CTRL writes while busy are dropped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= 32'h0000_0000;
      addr <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == `FES_REG_ADDR) begin
      addr <= {8'h00, reg_wdata[23:0]};
    end else if (start) begin
      ctrl <= {18'h00000, reg_wdata[13:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `FES_REG_CTRL: reg_rdata <= ctrl;
        `FES_REG_ADDR: reg_rdata <= addr;
        `FES_REG_STATUS: reg_rdata <= {31'h0000_0000, st != fes_pkg::hst_idle};
        `FES_REG_RDATA: reg_rdata <= rdata;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
    end else begin
      s1 <= {link.io1, link.io0};
      s2 <= s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: clock low for HALF+1 cycles, high for HALF-1; data changes at low start
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= fes_pkg::hst_idle;
      link.cs_b <= 1'b1;
      link.sclk <= 1'b0;
      link.hst_io0_out <= 1'b0;
      link.hst_io0_oe <= 1'b0;
      link.hst_io1_out <= 1'b0;
      link.hst_io1_oe <= 1'b0;
      tx <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
      ph <= 4'h0;
      ck <= 8'h00;
      tx_clks <= 8'h00;
      tot_clks <= 8'h00;
      gap <= 32'h0000_0000;
    end else begin
      unique case (st)
        fes_pkg::hst_idle: begin
          if (start) begin
            st <= fes_pkg::hst_sel;
            link.cs_b <= 1'b0;
            tx <= {reg_wdata[7:0], addr[23:0]};
            tx_clks <= next_tx_clks;
            tot_clks <= next_tx_clks +
              (reg_wdata[`FES_CTRL_DUAL] ? {2'h0, rdlen, 2'h0} : {1'b0, rdlen, 3'h0});
            rdata <= 32'h0000_0000;
            ph <= 4'h0;
            ck <= 8'h00;
          end
        end
        fes_pkg::hst_sel: begin
          if (ph == `FES_HALF_SCLK - 4'h1) begin
            st <= fes_pkg::hst_shift;
            ph <= 4'h0;
          end else begin
            ph <= ph + 4'h1;
          end
        end
        fes_pkg::hst_shift: begin
          ph <= ph + 4'h1;
          if (ph == 4'h0) begin
            link.hst_io0_oe <= ck < tx_clks;
            link.hst_io1_oe <= dual && ck >= `FES_TX_OPCODE_CLKS && ck < tx_clks;
            if (dual && ck >= `FES_TX_OPCODE_CLKS) begin
              link.hst_io1_out <= tx[31];
              link.hst_io0_out <= tx[30];
              tx <= {tx[29:0], 2'h0};
            end else begin
              link.hst_io0_out <= tx[31];
              tx <= {tx[30:0], 1'b0};
            end
          end
          if (ph == `FES_HALF_SCLK) begin
            link.sclk <= 1'b1;
          end
          if (ph == (`FES_HALF_SCLK << 1) - 4'h1) begin
            link.sclk <= 1'b0;
            ph <= 4'h0;
            if (ck >= tx_clks) begin
              rdata <= dual ? {rdata[29:0], s2} : {rdata[30:0], s2[1]};
            end
            if (ck == tot_clks - 8'h01) begin
              st <= fes_pkg::hst_desel;
            end else begin
              ck <= ck + 8'h01;
            end
          end
        end
        fes_pkg::hst_desel: begin
          link.hst_io0_oe <= 1'b0;
          link.hst_io1_oe <= 1'b0;
          if (ph == `FES_HALF_SCLK - 4'h1) begin
            link.cs_b <= 1'b1;
            st <= fes_pkg::hst_gap;
            if (ctrl[7:0] != `FES_OP_WAKE_PART) begin
              gap <= {28'h0000000, `FES_HALF_SCLK};
            end else if (tot_clks == tx_clks) begin
              gap <= RELEASE_CYC;
            end else begin
              gap <= RELEASE_CODE_CYC;
            end
          end else begin
            ph <= ph + 4'h1;
          end
        end
        fes_pkg::hst_gap: begin
          if (gap <= 32'h0000_0001) begin
            st <= fes_pkg::hst_idle;
          end else begin
            gap <= gap - 32'h0000_0001;
          end
        end
        default: begin
          st <= fes_pkg::hst_idle;
        end
      endcase
    end
  end

endmodule : fes_host

// ### bench/fes_checker_sva.sv
`timescale 1ns/1ps
module fes_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic hst_io0_out,
  input wire logic hst_io0_oe,
  input wire logic hst_io1_oe,
  input wire logic dev_io0_out,
  input wire logic dev_io0_oe,
  input wire logic dev_io1_out,
  input wire logic dev_io1_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic sclk_q;
  logic [7:0] edges;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
  end

  // Rising serial edges seen in this frame
  always_ff @(posedge clk) begin
    if (!rst_b || cs_b) begin
      edges <= 8'h00;
    end else if (sclk && !sclk_q) begin
      edges <= edges + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_lead_in;
    (!sclk)[*3] ##[1:30] sclk;
  endsequence

  a_reset_idle: assert property ($rose(rst_b) |-> cs_b && !sclk && !hst_io0_oe &&
    !dev_io0_oe && !dev_io1_oe) else $error("link not idle after reset");
  a_lead_in: assert property ($fell(cs_b) |-> (!cs_b) throughout s_lead_in)
    else $error("frame start malformed");
  a_clk_in_frame: assert property (sclk |-> !cs_b)
    else $error("serial clock outside frame");
  // Dual phases move a byte in four clocks, so only four-clock units are sure
  a_whole_units: assert property ($rose(cs_b) |-> edges >= 8'h08 && edges[1:0] == 2'h0)
    else $error("frame not whole units");
  a_rise_after_bit: assert property ($rose(cs_b) |-> !sclk && !$past(sclk))
    else $error("select rose inside a bit");
  a_no_fight: assert property (!(hst_io0_oe && dev_io0_oe) && !(hst_io1_oe && dev_io1_oe))
    else $error("both ends drive a data line");
  a_dev_quiet: assert property (cs_b [*4] |-> !dev_io0_oe && !dev_io1_oe)
    else $error("device drives while deselected");
  a_host_hold: assert property (sclk && $past(sclk) && hst_io0_oe |-> $stable(hst_io0_out))
    else $error("host data moved in high phase");
  a_dev_hold: assert property (sclk && $past(sclk) && dev_io1_oe |-> $stable(dev_io1_out) &&
    (!dev_io0_oe || $stable(dev_io0_out))) else $error("device data moved in high phase");
endmodule : fes_checker

// ### bench/tb_flash_erase_sleep_id_commands.sv
`timescale 1ns/1ps
module tb_flash_erase_sleep_id_commands;
  localparam int BE = 300;
  localparam int CE = 1000;
  // Arbitrary identification values
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] PT = 8'hC3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] protect = 5'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic busy_flag;
  logic write_latch;
  logic deep_sleep;
  logic erasing_chip;
  logic [6:0] erase_block;
  logic [31:0] rv;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  fes_if link ();
  fes_device #(.BLOCK_ERASE_CYC(BE), .CHIP_ERASE_CYC(CE), .MAKER_CODE(MK), .PART_CODE(PT))
    fes_device_i (.link(link), .clk(clk), .rst_b(rst_b), .protect(protect),
    .busy_flag(busy_flag), .write_latch(write_latch), .deep_sleep(deep_sleep),
    .erasing_chip(erasing_chip), .erase_block(erase_block));
  fes_host fes_host_i (.link(link), .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fes_checker fes_checker_i (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b), .sclk(link.sclk),
    .hst_io0_out(link.hst_io0_out), .hst_io0_oe(link.hst_io0_oe),
    .hst_io1_oe(link.hst_io1_oe), .dev_io0_out(link.dev_io0_out),
    .dev_io0_oe(link.dev_io0_oe), .dev_io1_out(link.dev_io1_out),
    .dev_io1_oe(link.dev_io1_oe));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
    @(posedge clk);
  endtask : rd

  // One whole frame; mode is {dual, address bytes}; ends on a falling edge
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [1:0] mode,
                     input logic [3:0] nrd);
    int i;
    @(posedge clk);
    wr(4'h4, {8'h00, a});
    // Let the lowered strobe reach an edge before raising it again
    @(posedge clk);
    wr(4'h0, {18'h0, nrd, mode, op});
    for (i = 0; i < 2000; i++) begin
      rd(4'h8);
      if (rv[0] === 1'b0) break;
    end
    check("host done", {31'h0, rv[0]}, 32'h0);
    rd(4'hC);
    @(negedge clk);
  endtask : run

  task automatic erase_done(input int lim);
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("busy end", {31'h0, busy_flag}, 32'h0);
  endtask : erase_done

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_block();
    check("select idle", {31'h0, link.cs_b}, 32'h1);
    check("sleep at start", {31'h0, deep_sleep}, 32'h0);
    run(8'hD8, 24'h010000, 2'h1, 4'h0);
    check("erase without latch", {31'h0, busy_flag}, 32'h0);
    run(8'h06, 24'h0, 2'h0, 4'h0);
    run(8'hD8, 24'h123456, 2'h0, 4'h0);
    check("short block erase", {31'h0, busy_flag}, 32'h0);
    check("latch kept", {31'h0, write_latch}, 32'h1);
    run(8'hC7, 24'h0, 2'h1, 4'h0);
    check("long chip erase", {31'h0, busy_flag}, 32'h0);
    run(8'hD8, 24'h12FFFF, 2'h1, 4'h0);
    check("block erase busy", {31'h0, busy_flag}, 32'h1);
    check("erase kind", {31'h0, erasing_chip}, 32'h0);
    check("erased block", {25'h0, erase_block}, 32'h12);
    check("latch cleared", {31'h0, write_latch}, 32'h0);
    erase_done(BE + 20);
  endtask : t_block

  task automatic t_protect();
    @(posedge clk);
    protect <= 5'h01;
    run(8'h06, 24'h0, 2'h0, 4'h0);
    run(8'hD8, 24'h7F0000, 2'h1, 4'h0);
    check("protected block", {31'h0, busy_flag}, 32'h0);
    run(8'h60, 24'h0, 2'h0, 4'h0);
    check("protected chip", {31'h0, busy_flag}, 32'h0);
    @(posedge clk);
    protect <= 5'h00;
    run(8'h60, 24'h0, 2'h0, 4'h0);
    check("chip erase busy", {31'h0, busy_flag}, 32'h1);
    check("chip erase kind", {31'h0, erasing_chip}, 32'h1);
    run(8'hB9, 24'h0, 2'h0, 4'h0);
    repeat (40) @(negedge clk);
    check("sleep while busy", {31'h0, deep_sleep}, 32'h0);
    run(8'h90, 24'h0, 2'h1, 4'h2);
    check("id while busy", {16'h0, rv[15:0]}, 32'h0000FFFF);
    check("erase unaffected", {31'h0, busy_flag}, 32'h1);
    erase_done(CE);
    run(8'h06, 24'h0, 2'h0, 4'h0);
    run(8'hC7, 24'h0, 2'h0, 4'h0);
    check("second chip opcode", {31'h0, busy_flag}, 32'h1);
    erase_done(CE);
  endtask : t_protect

  task automatic t_sleep();
    run(8'hB9, 24'h0, 2'h0, 4'h0);
    check("sleep entry delayed", {31'h0, deep_sleep}, 32'h0);
    repeat (40) @(negedge clk);
    check("sleep entered", {31'h0, deep_sleep}, 32'h1);
    run(8'h06, 24'h0, 2'h0, 4'h0);
    check("latch in sleep", {31'h0, write_latch}, 32'h0);
    run(8'h90, 24'h0, 2'h1, 4'h2);
    check("id in sleep", {16'h0, rv[15:0]}, 32'h0000FFFF);
    run(8'hAB, 24'h0, 2'h0, 4'h0);
    check("released", {31'h0, deep_sleep}, 32'h0);
    run(8'h06, 24'h0, 2'h0, 4'h0);
    check("latch after wake", {31'h0, write_latch}, 32'h1);
    run(8'hB9, 24'h0, 2'h0, 4'h0);
    repeat (40) @(negedge clk);
    run(8'hAB, 24'h0, 2'h1, 4'h2);
    check("wake with code", {16'h0, rv[15:0]}, {16'h0, PT, PT});
    check("awake after code", {31'h0, deep_sleep}, 32'h0);
  endtask : t_sleep

  task automatic t_ids();
    int i;
    for (i = 0; i < 4; i++) begin
      run(i[1] ? 8'h92 : 8'h90, {23'h0, i[0]}, {i[1], 1'b1}, 4'h2);
      check("id order", {16'h0, rv[15:0]}, i[0] ? {16'h0, PT, MK} : {16'h0, MK, PT});
    end
    run(8'hAB, 24'h0, 2'h1, 4'h3);
    check("part repeats", {8'h0, rv[23:0]}, {8'h0, PT, PT, PT});
  endtask : t_ids

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Whole run needs about eight thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    t_block();
    t_protect();
    t_sleep();
    t_ids();
    final_report();
  end
endmodule : tb_flash_erase_sleep_id_commands
